// file: core/utpc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module utpc_ctrl
  import utpc_pkg::*;
#(
  parameter int FLOAT_CYCLES = UTPC_FLOAT_CYCLES
)(
  input  wire logic        hclk,                 // system clock
  input  wire logic        hresetn,              // async reset, active low
  input  wire logic        hsel,                 // slave select
  input  wire logic [31:0] haddr,                // address
  input  wire logic [1:0]  htrans,               // transfer type
  input  wire logic        hwrite,               // write flag
  input  wire logic [2:0]  hsize,                // transfer size
  input  wire logic [31:0] hwdata,               // write data
  input  wire logic        hready,               // bus ready
  output logic      [31:0] hrdata,               // read data
  output logic             hreadyout,            // slave ready
  output logic             hresp,                // response
  output logic             line_plus_io_o,       // plus line drive value
  output logic             line_plus_io_oe,      // plus line drive enable
  input  wire logic        line_plus_io_i,       // plus line level
  output logic             line_minus_io_o,      // minus line drive value
  output logic             line_minus_io_oe,     // minus line drive enable
  input  wire logic        line_minus_io_i,      // minus line level
  input  wire logic        single_ended_rx_out,  // device receive output
  output logic             dir_enum_o,           // variant one direction/enumerate value
  output logic             dir_enum_oe,          // enable; low lets it float
  output logic             rx_outputs_enable,    // variant one rx enable
  output logic             oe_n,                 // variant two output enable, active low
  output logic             enumerate,            // variant two enumerate
  output logic             suspend_in,           // suspend
  output logic             mode,                 // 1 differential, 0 single-ended
  output logic             speed                 // 1 full speed, 0 low speed
);
  initial begin
    if (FLOAT_CYCLES < 1 || FLOAT_CYCLES > 255)
      $error("utpc_ctrl: FLOAT_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave, zero wait
  logic [6:0]            ctrl;
  logic [1:0]            txd;
  logic                  wr_pend;
  logic [31:0]           wr_addr;
  logic [6:0]            next_ctrl;
  logic [1:0]            next_txd;
  logic                  next_wr_pend;
  logic [31:0]           next_wr_addr;
  logic [UTPC_CNT_W-1:0] flt_cnt;
  logic [UTPC_CNT_W-1:0] next_flt_cnt;
  logic                  flt_done;
  logic                  next_flt_done;
  logic [2:0]            rx_s1;
  logic [2:0]            rx_s2;
  logic [31:0]           next_hrdata;
  logic                  rd_go;

  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] r);
    addr_is = (a[7:2] == r[7:2]);
  endfunction

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_go     = hsel && hready && htrans[1] && !hwrite;

  ////////////////////////////////////////////////////////////////////////////
  // reenumeration timer: counts while the direction pin floats
  always_comb
  begin
    next_wr_pend  = hsel && hready && htrans[1] && hwrite;
    next_wr_addr  = next_wr_pend ? haddr : wr_addr;
    next_ctrl     = ctrl;
    next_txd      = txd;
    next_flt_cnt  = flt_cnt;
    next_flt_done = flt_done;
    if (wr_pend && addr_is(wr_addr, UTPC_CTRL_ADDR))
    begin
      next_ctrl = hwdata[6:0];
    end
    if (wr_pend && addr_is(wr_addr, UTPC_TXD_ADDR))
    begin
      next_txd = hwdata[1:0];
    end
    if (!ctrl[UTPC_CTRL_VARIANT] && ctrl[UTPC_CTRL_REENUM])
    begin
      if (flt_cnt < UTPC_CNT_W'(FLOAT_CYCLES))
        next_flt_cnt = flt_cnt + 1'b1;
      else
        next_flt_done = 1'b1;
    end
    else
    begin
      next_flt_cnt  = '0;
      next_flt_done = 1'b0;
    end
    next_hrdata = 32'h0000_0000;
    if (rd_go && addr_is(haddr, UTPC_CTRL_ADDR))
      next_hrdata[6:0] = ctrl;
    else if (rd_go && addr_is(haddr, UTPC_TXD_ADDR))
      next_hrdata[1:0] = txd;
    else if (rd_go && addr_is(haddr, UTPC_STATUS_ADDR))
    begin
      next_hrdata[UTPC_ST_PLUS]  = rx_s2[0];
      next_hrdata[UTPC_ST_MINUS] = rx_s2[1];
      next_hrdata[UTPC_ST_RCV]   = rx_s2[2];
      next_hrdata[UTPC_ST_SE0]   = !rx_s2[0] && !rx_s2[1];
      next_hrdata[UTPC_ST_FLOAT] = !dir_enum_oe;
      next_hrdata[UTPC_ST_DONE]  = flt_done;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl     <= UTPC_CTRL_RESET;
      txd      <= 2'h0;
      wr_pend  <= 1'b0;
      wr_addr  <= 32'h0000_0000;
      flt_cnt  <= '0;
      flt_done <= 1'b0;
      hrdata   <= 32'h0000_0000;
      rx_s1    <= 3'h0;
      rx_s2    <= 3'h0;
    end
    else
    begin
      ctrl     <= next_ctrl;
      txd      <= next_txd;
      wr_pend  <= next_wr_pend;
      wr_addr  <= next_wr_addr;
      flt_cnt  <= next_flt_cnt;
      flt_done <= next_flt_done;
      hrdata   <= next_hrdata;
      rx_s1    <= {single_ended_rx_out, line_minus_io_i, line_plus_io_i};
      rx_s2    <= rx_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive from control state
  logic rx_sel;
  logic var2;
  assign rx_sel = ctrl[UTPC_CTRL_RX] || ctrl[UTPC_CTRL_SUSPEND_IN];
  assign var2   = ctrl[UTPC_CTRL_VARIANT];

  always_comb
  begin
    suspend_in        = ctrl[UTPC_CTRL_SUSPEND_IN];
    mode              = ctrl[UTPC_CTRL_MODE];
    speed             = ctrl[UTPC_CTRL_SPEED];
    enumerate         = ctrl[UTPC_CTRL_ENUM];
    oe_n              = rx_sel;
    // direction and rx enable move together except in suspend, where rx enable stays low; never the conflict state
    dir_enum_o        = rx_sel;
    rx_outputs_enable = rx_sel && !ctrl[UTPC_CTRL_SUSPEND_IN];
    dir_enum_oe       = !(!var2 && ctrl[UTPC_CTRL_REENUM]);
    line_plus_io_oe   = !rx_sel;
    line_minus_io_oe  = !rx_sel;
    line_plus_io_o    = txd[UTPC_TXD_PLUS];
    // single-ended mode: minus high forces SE0, low gives normal data
    line_minus_io_o   = txd[UTPC_TXD_MINUS];
    if (!rx_sel && !var2 && ctrl[UTPC_CTRL_RX])
      rx_outputs_enable = 1'b0;
  end
endmodule // utpc_ctrl
`default_nettype wire

// file: core/utpc_pkg.sv
// Summary of operation
// - variant one receive: direction/enumerate high, rx enable high, suspend low.
// - variant two receive: output enable bar high, suspend low; data on line pins.
// - variant one differential transmit: mode high, direction/rx enable/suspend low.
// - variant one single-ended transmit: mode, rx enable, suspend, direction, minus low.
// - variant two differential transmit: mode high, output enable bar and suspend low.
// - variant two single-ended transmit: mode, suspend, output enable, minus low.
// - never hold direction low with rx enable high and suspend low.
package utpc_pkg;
  localparam logic [31:0] UTPC_CTRL_ADDR   = 32'h0000_0000;
  localparam logic [31:0] UTPC_TXD_ADDR    = 32'h0000_0004;
  localparam logic [31:0] UTPC_STATUS_ADDR = 32'h0000_0008;
  // control fields
  localparam int UTPC_CTRL_RX      = 0;
  localparam int UTPC_CTRL_MODE    = 1;
  localparam int UTPC_CTRL_SUSPEND_IN    = 2;
  localparam int UTPC_CTRL_ENUM    = 3;
  localparam int UTPC_CTRL_SPEED   = 4;
  localparam int UTPC_CTRL_VARIANT = 5;
  localparam int UTPC_CTRL_REENUM  = 6;
  localparam logic [6:0] UTPC_CTRL_RESET = 7'h19;
  // tx data fields
  localparam int UTPC_TXD_PLUS  = 0;
  localparam int UTPC_TXD_MINUS = 1;
  // status fields
  localparam int UTPC_ST_PLUS  = 0;
  localparam int UTPC_ST_MINUS = 1;
  localparam int UTPC_ST_RCV   = 2;
  localparam int UTPC_ST_SE0   = 3;
  localparam int UTPC_ST_FLOAT = 4;
  localparam int UTPC_ST_DONE  = 5;
  // float time for reenumeration
  localparam int UTPC_CLK_MHZ       = 100;
  localparam int UTPC_FLOAT_NS      = 200;
  localparam int UTPC_FLOAT_MARGIN  = 2;
  localparam int UTPC_FLOAT_CYCLES  =
    (UTPC_FLOAT_NS * UTPC_FLOAT_MARGIN * UTPC_CLK_MHZ + 999) / 1000;
  localparam int UTPC_CNT_W = 8;
endpackage

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import utpc_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, var2 = 0, host_dp = 1, host_dm = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, termination_pullup;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, line_plus_io_o, line_plus_io_oe, line_plus_io_i, dp, dm;
  logic line_minus_io_o, line_minus_io_oe, line_minus_io_i, single_ended_rx_out, dir_enum_o;
  logic dir_enum_oe, rx_outputs_enable, oe_n, enumerate, suspend_in, mode, speed;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  assign hready = hreadyout;
  utpc_ctrl #(.FLOAT_CYCLES(4)) utpc_ctrl_inst (.*);
  utpc_dev_model utpc_dev_model_inst (.*);
  initial forever #5 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task test_done;
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge hclk)
    if (++cyc == 3000)
    begin
      n_mismatch++;
      test_done();
    end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    xfer(1'h0, UTPC_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h19, rd);
    for (int i = 0; i < 3; i++)
    begin
      {host_dp, host_dm} <= 2'h2 >> i;
      repeat (4) @(posedge hclk);
      xfer(1'h0, UTPC_STATUS_ADDR, 32'h0);
      chk("status", (i == 0) ? 32'h5 : (i == 1) ? 32'h2 : 32'h8, rd);
    end
    for (int m = 0; m < 2; m++)
      for (int v = 0; v < 4; v++)
      begin
        xfer(1'h1, UTPC_CTRL_ADDR, m ? 32'h12 : 32'h10);
        xfer(1'h1, UTPC_TXD_ADDR, v);
        #1;
        chk("pins", {m ? {v[0], v[1]} : (v[1] ? 2'h0 : {v[0], !v[0]}), 3'h4},
            {dp, dm, line_plus_io_oe, rx_outputs_enable, dir_enum_o});
      end
    {host_dp, host_dm} <= 2'h2;
    xfer(1'h1, UTPC_CTRL_ADDR, 32'h14);
    #1;
    chk("suspend_in", 3'h1, {line_plus_io_oe, single_ended_rx_out, dp});
    var2 <= 1'h1;
    for (int c = 0; c < 4; c++)
    begin
      xfer(1'h1, UTPC_CTRL_ADDR, 32'h21 | (c[0] << 3) | (c[1] << 4));
      #1;
      chk("pull", {oe_n, termination_pullup}, {1'h1, c[0] ? {c[1], !c[1]} : 2'h0});
    end
    xfer(1'h1, UTPC_CTRL_ADDR, 32'h22);
    #1;
    chk("oe", 1'h0, oe_n);
    xfer(1'h1, UTPC_CTRL_ADDR, 32'h20);
    xfer(1'h1, UTPC_TXD_ADDR, 32'h1);
    #1;
    chk("se_tx", 3'h4, {dp, dm, oe_n});
    var2 <= 1'h0;
    xfer(1'h1, UTPC_CTRL_ADDR, 32'h59);
    repeat (8) @(posedge hclk);
    xfer(1'h0, UTPC_STATUS_ADDR, 32'h0);
    chk("float", {dir_enum_oe, termination_pullup, rd[5:4]}, 5'h3);
    test_done();
  end
endmodule // tb_top
`default_nettype wire

// file: testbench/utpc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module utpc_ctrl_props
  import utpc_pkg::*;
(
  input wire logic        hclk,              // clock
  input wire logic        hresetn,           // reset
  input wire logic        hsel,              // select
  input wire logic [31:0] haddr,             // address
  input wire logic [1:0]  htrans,            // type
  input wire logic        hwrite,            // write
  input wire logic [31:0] hwdata,            // data
  input wire logic        line_plus_io_o,    // plus
  input wire logic        line_plus_io_oe,   // plus en
  input wire logic        line_minus_io_o,   // minus
  input wire logic        line_minus_io_oe,  // minus en
  input wire logic        dir_enum_o,        // dir
  input wire logic        dir_enum_oe,       // dir en
  input wire logic        rx_outputs_enable, // rx en
  input wire logic        suspend_in,        // suspend
  input wire logic        mode               // mode
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic tx1;
  logic wtx;
  logic wct;
  assign tx1 = dir_enum_oe && !dir_enum_o;
  assign wtx = hsel && htrans[1] && hwrite && haddr == UTPC_TXD_ADDR;
  assign wct = hsel && htrans[1] && hwrite && haddr == UTPC_CTRL_ADDR;
  ////////////////////////////////////////////////////////////////////////
  chk_no_conflict: assert property (tx1 && !suspend_in |-> !rx_outputs_enable)
    else $error("rx enable high while transmitting");
  chk_pin_pair: assert property (line_plus_io_oe == line_minus_io_oe)
    else $error("line enables differ");
  chk_suspend_in_rx: assert property (suspend_in |-> !line_plus_io_oe)
    else $error("lines driven in suspend");
  chk_txd_plus: assert property (wtx ##1 1 |=> line_plus_io_o == $past(hwdata[0]))
    else $error("plus line not from tx data");
  chk_txd_minus: assert property (wtx ##1 1 |=> line_minus_io_o == $past(hwdata[1]))
    else $error("minus line not from tx data");
  chk_ctrl_mode: assert property (wct ##1 1 |=> mode == $past(hwdata[1]))
    else $error("mode not from control");
  chk_ctrl_suspend_in: assert property (wct ##1 1 |=> suspend_in == $past(hwdata[2]))
    else $error("suspend not from control");
  chk_reset_vals: assert property ($rose(hresetn) |-> dir_enum_o && rx_outputs_enable)
    else $error("not receiving after reset");
  cover property (wtx);
  cover property (tx1);
  cover property (!dir_enum_oe);
endmodule // utpc_ctrl_props
bind utpc_ctrl utpc_ctrl_props utpc_ctrl_props_inst (.*);
`default_nettype wire

// file: testbench/utpc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module utpc_dev_model (
  input  wire logic       var2,                // second variant
  input  wire logic       host_dp,             // host D+
  input  wire logic       host_dm,             // host D-
  input  wire logic       line_plus_io_o,      // plus in
  input  wire logic       line_plus_io_oe,     // plus en
  input  wire logic       line_minus_io_o,     // minus in
  input  wire logic       dir_enum_o,          // dir
  input  wire logic       dir_enum_oe,         // dir en
  input  wire logic       rx_outputs_enable,   // rx en
  input  wire logic       oe_n,                // oe, low
  input  wire logic       enumerate,           // enumerate
  input  wire logic       suspend_in,          // suspend
  input  wire logic       mode,                // mode
  input  wire logic       speed,               // speed
  output logic            line_plus_io_i,      // plus level
  output logic            line_minus_io_i,     // minus level
  output logic            single_ended_rx_out, // rcv
  output logic            dp,                  // D+
  output logic            dm,                  // D-
  output logic [1:0]      termination_pullup   // on D+, on D-
);
  logic drive;
  logic rx_on;
  always_comb
  begin
    drive = !suspend_in && (var2 ? !oe_n : dir_enum_oe && !dir_enum_o);
    rx_on = suspend_in || (var2 ? oe_n : rx_outputs_enable);
    dp = drive ? (mode ? line_plus_io_o : line_plus_io_o && !line_minus_io_o) : host_dp;
    dm = drive ? (mode ? line_minus_io_o : !line_plus_io_o && !line_minus_io_o) : host_dm;
    // undriven outputs show the inverse so stale values never match
    line_plus_io_i = line_plus_io_oe ? line_plus_io_o : (rx_on ? dp : !dp);
    line_minus_io_i = line_plus_io_oe ? line_minus_io_o : (rx_on ? dm : !dm);
    single_ended_rx_out = !suspend_in && dp;
    termination_pullup = (var2 ? enumerate : dir_enum_oe) ? {speed, !speed} : 2'h0;
  end
endmodule // utpc_dev_model
`default_nettype wire
